/* File: verilog/timer_consts.svh */
// Constants for the prescaled start/stop timer
// Overview of operation
// R1 - After reset the timer is stopped and waits for a software start.
// R2 - Software loads prescaler and counter before issuing the start.
// R3 - Prescaler and counter are read as separate bytes; values may tear.
// R4 - In period mode writing 0 clears edge or underflow flag; 1 keeps it.
// R5 - Software writes 1 to flags it wants kept, avoiding read-modify-write.
// R6 - After entering period mode software clears both flags before start.
// R7 - Edge flag may set on the first prescaler underflow after start.
// R8 - Software waits two prescaler periods after start, then clears edge.
// R9 - Status flag follows a start within zero to one count-source cycle.
// R10 - Counting begins on the first source edge after status is set.
// R11 - Status flag follows a stop within zero to one source cycle.
// R12 - Software touches only the status flag until it follows a command.
// R13 - Prescaler rewrites while counting are three source cycles apart.
// R14 - Counter rewrites while counting are three underflows apart.
// R15 - Prescaler counts source edges; counter counts underflows; both reload.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define ADDR_CTRL 3'h0
`define ADDR_IOCTL 3'h1
`define ADDR_MODE 3'h2
`define ADDR_PRE 3'h3
`define ADDR_CNT 3'h4
`define ADDR_IRQ_STAT 3'h5
`define ADDR_IRQ_MASK 3'h6
`define CTRL_START 0
`define CTRL_STATUS 1
`define CTRL_EDGE 5
`define CTRL_UNDER 6
`define MODE_SEL_LSB 0
`define MODE_SRC_LSB 4
`define PRE_RESET 8'hFF
`define CNT_RESET 8'hFF
`define SRC_DIV_HI 8'h01
`define SRC_DIV_LO 8'h07
`define IRQ_UNDER 0
`define IRQ_EDGE 1
`endif

/* File: verilog/timer_pkg.sv */
// Types shared by the timer modules
package timer_pkg;
    typedef enum logic [2:0]
    {
        MODE_TIMER = 3'h0,
        MODE_PULSE_OUT = 3'h1,
        MODE_EVENT = 3'h2,
        MODE_PULSE_WIDTH = 3'h3,
        MODE_PERIOD = 3'h4
    } mode_t;
    typedef enum logic [1:0]
    {
        ST_STOPPED = 2'h0,
        ST_ARMING = 2'h1,
        ST_RUNNING = 2'h2,
        ST_HALTING = 2'h3
    } run_state_t;
endpackage

/* File: verilog/tick_if.sv */
// Count-source tick bundle between source divider and timer core
`timescale 1ns/10ps
interface tick_if;
    logic [1:0] sel;
    logic tick;
    modport src (input sel, output tick);
    modport core (output sel, input tick);
endinterface

/* File: verilog/count_source.sv */
// Count-source enable generator: system clock, divided system clock or external edge
`timescale 1ns/10ps
`include "timer_consts.svh"
module count_source
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic ext_in,
    tick_if.src tk
);
    logic [7:0] div_q;
    logic ext_q;
    logic [7:0] limit;

    always_comb
    begin
        limit = (tk.sel == 2'h1) ? `SRC_DIV_LO : `SRC_DIV_HI;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            div_q <= 8'h00;
        else if (div_q >= limit)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ext_q <= 1'b0;
        else
            ext_q <= ext_in;
    end

    always_comb
    begin
        unique case (tk.sel)
            2'h0: tk.tick = 1'b1;
            2'h1: tk.tick = (div_q == limit);
            2'h2: tk.tick = ext_in & ~ext_q;
            default: tk.tick = (div_q == limit);
        endcase
    end
endmodule

/* File: verilog/prescaled_timer.sv */
// Prescaled down-counting timer with start/stop sync and register port
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "timer_consts.svh"
module prescaled_timer
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_src_in,
    input wire logic meas_in,
    output logic [7:0] rdata_out,
    output logic underflow_out,
    output logic irq_out
);
    tick_if tk ();

    logic count_start_bit_q;
    timer_pkg::run_state_t state_q;
    logic [7:0] prescaler_reg_q;
    logic [7:0] timer_counter_reg_q;
    logic [7:0] pre_cnt_q;
    logic [7:0] tmr_cnt_q;
    logic [7:0] timer_io_control_reg_q;
    logic [7:0] timer_mode_reg_q;
    logic active_edge_flag_q;
    logic underflow_flag_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic meas_q;
    logic meas_edge_q;
    logic first_under_q;
    logic count_status_flag;
    logic counting;
    logic pre_under;
    logic tmr_under;
    logic wr_ctrl;
    logic meas_edge;
    logic period_mode;

    count_source u_src
    (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .ext_in(ext_src_in),
        .tk(tk)
    );

    assign tk.sel = timer_mode_reg_q[`MODE_SRC_LSB +: 2];
    assign period_mode = (timer_mode_reg_q[`MODE_SEL_LSB +: 3] == timer_pkg::MODE_PERIOD);
    assign count_status_flag = (state_q == timer_pkg::ST_RUNNING)
        || (state_q == timer_pkg::ST_HALTING);
    assign counting = (state_q == timer_pkg::ST_RUNNING) && tk.tick; // R10
    assign pre_under = counting && (pre_cnt_q == 8'h00);
    assign tmr_under = pre_under && (tmr_cnt_q == 8'h00);
    assign wr_ctrl = wr_in && (addr_in == `ADDR_CTRL);
    assign meas_edge = meas_in & ~meas_q;

    // Start bit; cleared by reset so the timer idles stopped
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            count_start_bit_q <= 1'b0; // R1
        else if (wr_ctrl)
            count_start_bit_q <= wdata_in[`CTRL_START];
    end

    // Status follows start bit on the next count-source tick
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_q <= timer_pkg::ST_STOPPED; // R1
        else
        begin
            unique case (state_q)
                timer_pkg::ST_STOPPED:
                    if (count_start_bit_q)
                        state_q <= tk.tick ? timer_pkg::ST_RUNNING : timer_pkg::ST_ARMING; // R9
                timer_pkg::ST_ARMING:
                    if (!count_start_bit_q)
                        state_q <= timer_pkg::ST_STOPPED;
                    else if (tk.tick)
                        state_q <= timer_pkg::ST_RUNNING; // R9
                timer_pkg::ST_RUNNING:
                    if (!count_start_bit_q)
                        state_q <= tk.tick ? timer_pkg::ST_STOPPED : timer_pkg::ST_HALTING; // R11
                timer_pkg::ST_HALTING:
                    if (count_start_bit_q)
                        state_q <= timer_pkg::ST_RUNNING;
                    else if (tk.tick)
                        state_q <= timer_pkg::ST_STOPPED; // R11
            endcase
        end
    end

    // Reload values; while stopped a write also loads the counter
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            prescaler_reg_q <= `PRE_RESET;
            timer_counter_reg_q <= `CNT_RESET;
        end
        else if (wr_in)
        begin
            if (addr_in == `ADDR_PRE)
                prescaler_reg_q <= wdata_in;
            if (addr_in == `ADDR_CNT)
                timer_counter_reg_q <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pre_cnt_q <= `PRE_RESET;
        else if (wr_in && (addr_in == `ADDR_PRE) && !count_status_flag)
            pre_cnt_q <= wdata_in;
        else if (pre_under)
            pre_cnt_q <= prescaler_reg_q; // R15
        else if (counting)
            pre_cnt_q <= pre_cnt_q - 8'h01; // R15
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            tmr_cnt_q <= `CNT_RESET;
        else if (wr_in && (addr_in == `ADDR_CNT) && !count_status_flag)
            tmr_cnt_q <= wdata_in;
        else if (tmr_under)
            tmr_cnt_q <= timer_counter_reg_q; // R15
        else if (pre_under)
            tmr_cnt_q <= tmr_cnt_q - 8'h01; // R15
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            timer_io_control_reg_q <= 8'h00;
            timer_mode_reg_q <= 8'h00;
        end
        else if (wr_in)
        begin
            if (addr_in == `ADDR_IOCTL)
                timer_io_control_reg_q <= wdata_in;
            if (addr_in == `ADDR_MODE)
                timer_mode_reg_q <= wdata_in;
        end
    end

    // Measured-input edge, polarity from io control bit 0
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            meas_q <= 1'b0;
        else
            meas_q <= meas_in;
    end

    // Edge is latched and, in period mode, reported at the next prescaler underflow; new edge wins
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            meas_edge_q <= 1'b0;
        else if (timer_io_control_reg_q[0] ? (~meas_in & meas_q) : meas_edge)
            meas_edge_q <= 1'b1;
        else if (pre_under)
            meas_edge_q <= 1'b0;
    end

    // Armed while stopped; in period mode the first underflow after start marks the edge flag
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            first_under_q <= 1'b0;
        else if (!count_status_flag)
            first_under_q <= 1'b1; // R7
        else if (pre_under)
            first_under_q <= 1'b0;
    end

    // Flags, period mode only: write 0 clears, write 1 keeps, hardware set wins
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            active_edge_flag_q <= 1'b0;
        else if (period_mode && pre_under && (meas_edge_q || first_under_q))
            active_edge_flag_q <= 1'b1; // R7
        else if (wr_ctrl && period_mode && !wdata_in[`CTRL_EDGE])
            active_edge_flag_q <= 1'b0; // R4
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            underflow_flag_q <= 1'b0;
        else if (period_mode && tmr_under)
            underflow_flag_q <= 1'b1;
        else if (wr_ctrl && period_mode && !wdata_in[`CTRL_UNDER])
            underflow_flag_q <= 1'b0; // R4
    end

    // Interrupt status: write 1 clears, new event wins
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_stat_q <= 2'h0;
        else
            irq_stat_q <= (irq_stat_q & ~((wr_in && addr_in == `ADDR_IRQ_STAT) ? wdata_in[1:0] : 2'h0))
                | {period_mode && pre_under && meas_edge_q, tmr_under};
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_mask_q <= 2'h0;
        else if (wr_in && addr_in == `ADDR_IRQ_MASK)
            irq_mask_q <= wdata_in[1:0];
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            underflow_out <= 1'b0;
        else
            underflow_out <= tmr_under;
    end

    assign irq_out = |(irq_stat_q & irq_mask_q);

    // Byte-wide reads; each counter byte is sampled on its own access
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
        begin
            unique case (addr_in)
                `ADDR_CTRL: rdata_out <= {1'b0, underflow_flag_q, active_edge_flag_q, 3'h0,
                    count_status_flag, count_start_bit_q};
                `ADDR_IOCTL: rdata_out <= timer_io_control_reg_q;
                `ADDR_MODE: rdata_out <= timer_mode_reg_q;
                `ADDR_PRE: rdata_out <= pre_cnt_q; // R3
                `ADDR_CNT: rdata_out <= tmr_cnt_q; // R3
                `ADDR_IRQ_STAT: rdata_out <= {6'h00, irq_stat_q};
                `ADDR_IRQ_MASK: rdata_out <= {6'h00, irq_mask_q};
                default: rdata_out <= 8'h00;
            endcase
        end
        else
            rdata_out <= 8'h00;
    end

    chk_reset_stopped: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R1
        (state_q == timer_pkg::ST_STOPPED) && !count_start_bit_q
        |=> state_q == timer_pkg::ST_STOPPED)
        else $error("timer left stopped state without start");
    chk_start_follow: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R9
        (state_q == timer_pkg::ST_ARMING && tk.tick && count_start_bit_q)
        |=> count_status_flag)
        else $error("status did not follow start");
    chk_stop_follow: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R11
        (count_status_flag && !count_start_bit_q && tk.tick) |=> !count_status_flag)
        else $error("status did not follow stop");
    chk_no_count_stop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R10
        !count_status_flag |=> $stable(tmr_cnt_q) || $past(wr_in))
        else $error("counter moved while stopped");
    chk_pre_reload: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R15
        pre_under && !wr_in |=> pre_cnt_q == $past(prescaler_reg_q))
        else $error("prescaler reload wrong");
    chk_flag_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R4
        wr_ctrl && period_mode && !wdata_in[`CTRL_UNDER] && !tmr_under |=> !underflow_flag_q)
        else $error("underflow flag not cleared");
    chk_flag_keep: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R4
        wr_ctrl && wdata_in[`CTRL_EDGE] && active_edge_flag_q |=> active_edge_flag_q)
        else $error("edge flag lost on write one");
    chk_first_edge: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R7
        period_mode && pre_under && first_under_q |=> active_edge_flag_q)
        else $error("first underflow edge flag missing");
    chk_read_byte: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // R3
        rd_in && addr_in == `ADDR_CNT |=> rdata_out == $past(tmr_cnt_q))
        else $error("counter byte read wrong");
endmodule

/* File: test/tb_prescaled_timer.sv */
// Self-checking bench for the prescaled start/stop timer
`timescale 1ns/10ps
`include "timer_consts.svh"
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb_prescaled_timer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic ext = 1'b0;
    logic meas = 1'b0;
    logic ext_run = 1'b0;
    logic [1:0] ext_cnt = 2'h0;
    logic [7:0] rdata;
    logic uf;
    logic irq;
    logic [7:0] d;
    logic [7:0] d2;
    int errors = 0;
    int check_count = 0;
    int g;
    int n;
    int divs[4] = '{1, 8, 4, 2};

    prescaled_timer DUT
    (
        .sys_clk_in(clk),
        .sys_rst_in(rst),
        .addr_in(addr),
        .wdata_in(wdata),
        .wr_in(wr_s),
        .rd_in(rd_s),
        .ext_src_in(ext),
        .meas_in(meas),
        .rdata_out(rdata),
        .underflow_out(uf),
        .irq_out(irq)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // External source: one rising edge every four clocks
    always @(posedge clk)
    begin
        ext_cnt <= ext_cnt + 2'h1;
        if (ext_run)
            ext <= ext_cnt[1];
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_st(input logic v);
        n = 0;
        rd(`ADDR_CTRL, d);
        while (d[`CTRL_STATUS] !== v && n < 4)
        begin
            rd(`ADDR_CTRL, d);
            n++;
        end
        `CHK(d[`CTRL_STATUS], v)
    endtask

    // Cycles between two underflow pulses
    task automatic uf_gap(output int c);
        c = 0;
        while (uf !== 1'b1 && c < 2000)
        begin
            @(posedge clk);
            #1 c++;
        end
        c = 0;
        do
        begin
            @(posedge clk);
            #1 c++;
        end
        while (uf !== 1'b1 && c < 2000);
    endtask

    task automatic results;
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #1000000;
        errors++;
        results;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK({uf, irq}, 2'b00)
        repeat (20) @(posedge clk);
        rd(`ADDR_CTRL, d);
        `CHK(d, 8'h00)
        rd(`ADDR_PRE, d);
        `CHK(d, `PRE_RESET)
        rd(`ADDR_CNT, d);
        `CHK(d, `CNT_RESET)
        wr(3'h7, 8'hA5);
        rd(3'h7, d);
        `CHK(d, 8'h00)
        wr(`ADDR_PRE, 8'h02);
        wr(`ADDR_CNT, 8'h03);
        wr(`ADDR_IRQ_MASK, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            wr(`ADDR_MODE, {2'b00, s[1:0], 1'b0, timer_pkg::MODE_TIMER});
            ext_run <= (s == 2);
            wr(`ADDR_CTRL, 8'h01);
            wait_st(1'b1);
            uf_gap(g);
            `CHK(g, 12 * divs[s])
            rd(`ADDR_PRE, d);
            rd(`ADDR_CNT, d2);
            `CHK(d <= 8'h02 && d2 <= 8'h03, 1'b1)
            wr(`ADDR_CTRL, 8'h00);
            wait_st(1'b0);
        end
        rd(`ADDR_CNT, d);
        repeat (30) @(posedge clk);
        rd(`ADDR_CNT, d2);
        `CHK(d2, d)
        rd(`ADDR_IRQ_STAT, d);
        `CHK(d[`IRQ_UNDER], 1'b1)
        `CHK(irq, 1'b1)
        wr(`ADDR_IRQ_MASK, 8'h00);
        @(posedge clk);
        #1 `CHK(irq, 1'b0)
        wr(`ADDR_IRQ_MASK, 8'h03);
        @(posedge clk);
        #1 `CHK(irq, 1'b1)
        wr(`ADDR_IRQ_STAT, 8'h01);
        rd(`ADDR_IRQ_STAT, d);
        `CHK(d[`IRQ_UNDER], 1'b0)
        `CHK(irq, 1'b0)
        // Period measurement
        wr(`ADDR_MODE, {5'h00, timer_pkg::MODE_PERIOD});
        wr(`ADDR_CNT, 8'h20);
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_CTRL, 8'h01);
        wait_st(1'b1);
        repeat (10) @(posedge clk);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_EDGE], 1'b1)
        wr(`ADDR_CTRL, 8'h41);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_EDGE], 1'b0)
        @(posedge clk);
        meas <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_EDGE], 1'b1)
        rd(`ADDR_IRQ_STAT, d);
        `CHK(d[`IRQ_EDGE], 1'b1)
        `CHK(irq, 1'b1)
        wr(`ADDR_CTRL, 8'h61);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_EDGE], 1'b1)
        wr(`ADDR_CTRL, 8'h41);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_EDGE], 1'b0)
        uf_gap(g);
        `CHK(g, 99)
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_UNDER], 1'b1)
        wr(`ADDR_CTRL, 8'h21);
        rd(`ADDR_CTRL, d);
        `CHK(d[`CTRL_UNDER], 1'b0)
        // Reload rewrites while counting, spaced as required
        wr(`ADDR_CNT, 8'h10);
        repeat (9) @(posedge clk);
        wr(`ADDR_CNT, 8'h09);
        wr(`ADDR_PRE, 8'h03);
        repeat (3) @(posedge clk);
        wr(`ADDR_PRE, 8'h04);
        uf_gap(g);
        `CHK(g, 50)
        wr(`ADDR_CTRL, 8'h60);
        wait_st(1'b0);
        results;
    end
endmodule
